// ==== dv/tb_tile_boot_and_security_loader.sv ====
// Testbench for the tile boot and security loader.
// Assumes the word source model; one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_tile_boot_and_security_loader;
  logic clk_i, rst_i, chip_rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, src_valid_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, lat;
  logic [31:0] wb_dat_i, wb_dat_o, src_data_i, otp_prog_data_o, ram_data_o, rd, sec;
  logic gpio_pulldown_o, src_rd_o, src_otp_o, ram_we_o, cpu_run_o, otp_prog_o;
  logic otp_prog_sec_o, jtag_block_o, link_block_o, otp_redund_o, jtag_otp_block_o;
  logic debug_pin_off_o;
  logic [15:0] src_addr_o, ram_addr_o, cpu_pc_o, otp_prog_addr_o;
  logic [9:0] user_id_o;
  logic [47:0] exp_q[$];
  logic [47:0] prog_last;
  logic prog_sec;
  int bad_count = 0;
  int num_checks = 0;
  int prog_cnt = 0;
  tbsl_loader u_tbsl_loader (.clk_i, .rst_i, .chip_rst_n_i, .gpio_pulldown_o, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .src_rd_o,
    .src_otp_o, .src_addr_o, .src_valid_i, .src_data_i, .ram_we_o, .ram_addr_o, .ram_data_o,
    .cpu_run_o, .cpu_pc_o, .otp_prog_o, .otp_prog_sec_o, .otp_prog_addr_o, .otp_prog_data_o,
    .jtag_block_o, .link_block_o, .otp_redund_o, .jtag_otp_block_o, .debug_pin_off_o,
    .user_id_o);
  tbsl_src_model u_tbsl_src_model (.clk_i, .rd_i(src_rd_o), .otp_i(src_otp_o),
    .addr_i(src_addr_o), .lat_i(lat), .valid_o(src_valid_i), .data_o(src_data_i));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_i) begin
    if (ram_we_o === 1'b1) begin
      if (exp_q.size() == 0) cmp(48'h0, 48'h1);
      else cmp({ram_addr_o, ram_data_o}, exp_q.pop_front());
    end
    if (otp_prog_o === 1'b1) begin
      prog_cnt++;
      prog_last = {otp_prog_addr_o, otp_prog_data_o};
      prog_sec = otp_prog_sec_o;
    end
  end
  function automatic logic [31:0] crc_add(input logic [31:0] c, input logic [31:0] w);
    for (int i = 0; i < 32; i++) c = (c[0] ^ w[i]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return c;
  endfunction
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // No cycle budget here; the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Mode 0 good check value, 1 skip value, 2 corrupt check value
  task automatic boot(input logic sb, input int n, input int mode);
    logic [31:0] c, w;
    int k;
    c = 32'hFFFFFFFF;
    sec = $urandom;
    sec[5] = sb;
    sec[12] = (mode == 2);
    sec[11:8] = 4'h2;
    u_tbsl_src_model.sec_word = sec;
    for (int i = 0; i <= n + 1; i++) begin
      w = (i == 0) ? n : $urandom;
      if (i == n + 1) w = (mode == 1) ? 32'h0D15AB1E : ~c ^ (mode == 2);
      else c = crc_add(c, w);
      if (i > 0 && i <= n) exp_q.push_back({16'(i - 1), w});
      u_tbsl_src_model.flash_mem[i] = sb ? ~w : w;
      u_tbsl_src_model.otp_mem[i] = sb ? w : ~w;
    end
    chip_rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp(gpio_pulldown_o, 1);
    chip_rst_n_i <= 1'b1;
    k = 0;
    while (src_rd_o !== 1'b1 && k < 16000) begin
      @(posedge clk_i);
      k++;
    end
    cmp(k >= 1495 && k <= 15000, 1);
    cmp(gpio_pulldown_o, 0);
    k = 0;
    while (cpu_run_o !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    cmp(cpu_run_o, mode != 2);
    cmp(exp_q.size(), 0);
    cmp(cpu_pc_o, 0);
    wb(1'b0, 8'h04, 32'h0);
    cmp({rd[7], rd[4], rd[3:0]}, (mode == 2) ? 6'h17 : 6'h26);
    wb(1'b0, 8'h14, 32'h0);
    cmp(rd, n);
    if (mode != 2) begin
      wb(1'b0, 8'h00, 32'h0);
      cmp(rd, sec);
      cmp({jtag_block_o, link_block_o, otp_redund_o, jtag_otp_block_o, debug_pin_off_o,
        user_id_o}, {sec[0], sec[1], sec[7], sec[13], sec[14], sec[31:22]});
    end
    $display("Boot test mode %0d done", mode);
  endtask
  task automatic prog(input logic [15:0] a, input logic ts, input logic deny);
    int p;
    logic [31:0] d;
    p = prog_cnt;
    d = $urandom;
    wb(1'b1, 8'h08, {16'h0, a});
    wb(1'b1, 8'h0C, d);
    wb(1'b1, 8'h10, {29'h0, 1'b1, ts, 1'b1});
    repeat (2) @(posedge clk_i);
    cmp(prog_cnt - p, !deny);
    wb(1'b0, 8'h04, 32'h0);
    cmp(rd[5], deny);
    if (!deny) cmp(prog_last, {a, d});
    if (!deny) cmp(prog_sec, ts);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    // Generous span: three boots are near 5000 cycles
    #300000;
    bad_count++;
    final_report;
  end
  initial begin
    rst_i = 1'b1;
    chip_rst_n_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    lat = 4'h0;
    void'($urandom(18901));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    boot(1'b0, 3, 0);
    prog(16'h0010, 1'b0, 1'b0);
    prog(16'h0200, 1'b0, 1'b1);
    prog(16'h0800, 1'b0, 1'b1);
    prog(16'h0800, 1'b1, 1'b0);
    wb(1'b0, 8'h3C, 32'h0);
    cmp(rd, 0);
    $display("Programming test done");
    lat <= 4'h3;
    boot(1'b1, 5, 1);
    lat <= 4'h1;
    boot(1'b0, 2, 2);
    prog(16'h0010, 1'b1, 1'b1);
    final_report;
  end
endmodule
`default_nettype wire

// ==== dv/tbsl_src_model.sv ====
// Word source model: flash and one-time array behind one read port.
// Assumes the loader holds its read request until it sees valid.
`timescale 1ns/100ps
`default_nettype none
module tbsl_src_model (
  input wire logic clk_i, // clock
  input wire logic rd_i, // read request
  input wire logic otp_i, // 1 one-time array
  input wire logic [15:0] addr_i, // word address
  input wire logic [3:0] lat_i, // answer delay
  output logic valid_o, // word present
  output logic [31:0] data_o // word, first byte low
);
  logic [31:0] flash_mem [0:63];
  logic [31:0] otp_mem [0:63];
  logic [31:0] sec_word;
  logic [3:0] wait_cnt = 4'h0;
  initial begin
    valid_o = 1'b0;
    data_o = 32'h0;
  end
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (rd_i && !valid_o && wait_cnt >= lat_i) begin
      valid_o <= 1'b1;
      wait_cnt <= 4'h0;
      if (otp_i && addr_i == 16'h0800) data_o <= sec_word;
      else if (otp_i) data_o <= otp_mem[addr_i[5:0]];
      else data_o <= flash_mem[addr_i[5:0]];
    end else begin
      // Stale word never left on the bus
      data_o <= ~data_o;
      if (rd_i && !valid_o) wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/tbsl_crc32.sv ====
// Word-wide CRC-32 engine, bytes taken least significant first.
// Assumes one data word per enable pulse; init and enable never together.
`timescale 1ns/100ps
`default_nettype none
module tbsl_crc32 (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic init_i, // reload the seed
  input wire logic en_i, // absorb one word
  input wire logic [31:0] data_i, // word, first byte in bits 7:0
  output logic [31:0] crc_o // inverted remainder
);
  logic [31:0] crc_reg;
  logic [31:0] crc_next;

  always_comb begin
    crc_next = crc_reg;
    for (int i = 0; i < 32; i++) begin
      if (crc_next[0] ^ data_i[i]) begin
        crc_next = (crc_next >> 1) ^ tbsl_pkg::CRC_POLY;
      end else begin
        crc_next = crc_next >> 1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || init_i) begin
      crc_reg <= tbsl_pkg::CRC_INIT;
    end else if (en_i) begin
      crc_reg <= crc_next;
    end
  end

  assign crc_o = ~crc_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_crc_seed;
    init_i |=> crc_o == ~tbsl_pkg::CRC_INIT;
  endproperty
  a_crc_seed: assert property (p_crc_seed) else $error("crc seed wrong");
endmodule
`default_nettype wire

// ==== verilog/tbsl_loader.sv ====
// Tile boot and security loader: reset sequence, security load, image boot, OTP guard.
// Assumes a word source (flash or OTP) answering a held read with a one-cycle valid.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tbsl_loader #(
  parameter int unsigned RAM_AW = 16
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // synchronous reset
  input wire logic chip_rst_n_i, // chip reset pin, low holds
  output logic gpio_pulldown_o, // pull-down enable on GPIO
  // Wishbone slave
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  // Boot word source
  output logic src_rd_o, // read request, held to valid
  output logic src_otp_o, // 1 OTP, 0 flash
  output logic [15:0] src_addr_o, // word address
  input wire logic src_valid_i, // word present, one cycle
  input wire logic [31:0] src_data_i, // word, first byte low
  // SRAM load port
  output logic ram_we_o, // write strobe
  output logic [RAM_AW-1:0] ram_addr_o, // word address
  output logic [31:0] ram_data_o, // word
  output logic cpu_run_o, // start processor
  output logic [RAM_AW-1:0] cpu_pc_o, // start word address
  // OTP programming
  output logic otp_prog_o, // program pulse
  output logic otp_prog_sec_o, // target is security register
  output logic [15:0] otp_prog_addr_o, // row address
  output logic [31:0] otp_prog_data_o, // row data
  // Security features
  output logic jtag_block_o, // block scan access to tile
  output logic link_block_o, // block switch access
  output logic otp_redund_o, // redundant rows on
  output logic jtag_otp_block_o, // block scan access to OTP
  output logic debug_pin_off_o, // debug sync pin disabled
  output logic [9:0] user_id_o // test-port user code extension
);
  // Refused at elaboration: the word source address is only 16 bits wide
  if (RAM_AW < 2 || RAM_AW > 16) begin : g_aw_check
    $error("RAM_AW must lie in 2..16");
  end

  // ----------------------------------------------------------------
  // Boot state machine
  // ----------------------------------------------------------------
  tbsl_pkg::tbsl_state_t state_reg;
  logic [tbsl_pkg::RST_CNT_W-1:0] cnt_reg;
  logic [31:0] sec_reg;
  logic loaded_reg;
  logic [31:0] len_reg;
  logic [31:0] left_reg;
  logic crc_err_reg;
  logic [31:0] crc_val;
  logic crc_init;
  logic crc_en;
  logic take;
  logic fetching;

  assign take = src_rd_o && src_valid_i;
  assign fetching = state_reg == tbsl_pkg::TBSL_SEC || state_reg == tbsl_pkg::TBSL_LEN ||
                    state_reg == tbsl_pkg::TBSL_PRG || state_reg == tbsl_pkg::TBSL_TRL;
  assign crc_init = state_reg == tbsl_pkg::TBSL_SEC && take;
  // Trailer word is excluded from the sum
  assign crc_en = take && (state_reg == tbsl_pkg::TBSL_LEN ||
                           state_reg == tbsl_pkg::TBSL_PRG);

  tbsl_crc32 u_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .init_i(crc_init),
    .en_i(crc_en),
    .data_i(src_data_i),
    .crc_o(crc_val)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i || !chip_rst_n_i) begin
      state_reg <= tbsl_pkg::TBSL_HOLD;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        tbsl_pkg::TBSL_HOLD: begin
          state_reg <= tbsl_pkg::TBSL_RSTSEQ;
          cnt_reg <= '0;
        end
        tbsl_pkg::TBSL_RSTSEQ: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == tbsl_pkg::RST_CNT_W'(tbsl_pkg::RST_SEQ_CYC - 1)) begin
            state_reg <= tbsl_pkg::TBSL_SEC;
          end
        end
        tbsl_pkg::TBSL_SEC: if (take) state_reg <= tbsl_pkg::TBSL_LEN;
        tbsl_pkg::TBSL_LEN: begin
          if (take) begin
            // Image larger than RAM cannot be placed
            if (src_data_i > 32'(1 << RAM_AW)) begin
              state_reg <= tbsl_pkg::TBSL_FAIL;
            end else if (src_data_i == 32'h00000000) begin
              state_reg <= tbsl_pkg::TBSL_TRL;
            end else begin
              state_reg <= tbsl_pkg::TBSL_PRG;
            end
          end
        end
        tbsl_pkg::TBSL_PRG: begin
          if (take && left_reg == 32'h00000001) state_reg <= tbsl_pkg::TBSL_TRL;
        end
        tbsl_pkg::TBSL_TRL: begin
          if (take) begin
            if (src_data_i == tbsl_pkg::CRC_SKIP || src_data_i == crc_val) begin
              state_reg <= tbsl_pkg::TBSL_RUN;
            end else begin
              state_reg <= tbsl_pkg::TBSL_FAIL;
            end
          end
        end
        tbsl_pkg::TBSL_RUN: state_reg <= tbsl_pkg::TBSL_RUN;
        tbsl_pkg::TBSL_FAIL: state_reg <= tbsl_pkg::TBSL_FAIL;
        default: state_reg <= tbsl_pkg::TBSL_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Source fetch and RAM load
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !chip_rst_n_i) begin
      src_rd_o <= 1'b0;
      src_otp_o <= 1'b1;
      src_addr_o <= tbsl_pkg::OTP_SEC_ADDR;
      ram_we_o <= 1'b0;
      ram_addr_o <= '0;
      ram_data_o <= '0;
      len_reg <= '0;
      left_reg <= '0;
    end else begin
      ram_we_o <= 1'b0;
      if (take) begin
        src_rd_o <= 1'b0;
      end else if (fetching) begin
        src_rd_o <= 1'b1;
      end
      if (take) begin
        case (state_reg)
          tbsl_pkg::TBSL_SEC: begin
            // OTP boot replaces the flash image; the flash image is then not loaded
            src_otp_o <= src_data_i[tbsl_pkg::SB_SEC_BOOT];
            src_addr_o <= tbsl_pkg::BOOT_BASE;
          end
          tbsl_pkg::TBSL_LEN: begin
            len_reg <= src_data_i;
            left_reg <= src_data_i;
            src_addr_o <= src_addr_o + 16'h0001;
            ram_addr_o <= '0;
          end
          tbsl_pkg::TBSL_PRG: begin
            ram_we_o <= 1'b1;
            ram_data_o <= src_data_i;
            left_reg <= left_reg - 32'h00000001;
            src_addr_o <= src_addr_o + 16'h0001;
          end
          default: begin
            src_addr_o <= src_addr_o;
          end
        endcase
      end
      if (ram_we_o) begin
        ram_addr_o <= ram_addr_o + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Security register and run control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_reg <= '0;
      loaded_reg <= 1'b0;
      cpu_run_o <= 1'b0;
      cpu_pc_o <= '0;
      crc_err_reg <= 1'b0;
      gpio_pulldown_o <= 1'b1;
    end else begin
      gpio_pulldown_o <= !chip_rst_n_i;
      if (!chip_rst_n_i) begin
        loaded_reg <= 1'b0;
        cpu_run_o <= 1'b0;
        crc_err_reg <= 1'b0;
      end else begin
        if (state_reg == tbsl_pkg::TBSL_SEC && take) begin
          sec_reg <= src_data_i;
          loaded_reg <= 1'b1;
        end
        if (state_reg == tbsl_pkg::TBSL_TRL && take) begin
          cpu_run_o <= src_data_i == tbsl_pkg::CRC_SKIP || src_data_i == crc_val;
          crc_err_reg <= src_data_i != tbsl_pkg::CRC_SKIP && src_data_i != crc_val;
          cpu_pc_o <= '0;
        end
      end
    end
  end

  // Restrictive until the register is loaded, so nothing leaks during boot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jtag_block_o <= 1'b1;
      link_block_o <= 1'b1;
      otp_redund_o <= 1'b0;
      jtag_otp_block_o <= 1'b1;
      debug_pin_off_o <= 1'b1;
      user_id_o <= '0;
    end else begin
      jtag_block_o <= !loaded_reg || sec_reg[tbsl_pkg::SB_NO_JTAG];
      link_block_o <= !loaded_reg || sec_reg[tbsl_pkg::SB_NO_LINK];
      otp_redund_o <= loaded_reg && sec_reg[tbsl_pkg::SB_REDUND];
      jtag_otp_block_o <= !loaded_reg || sec_reg[tbsl_pkg::SB_NO_JOTP];
      debug_pin_off_o <= !loaded_reg || sec_reg[tbsl_pkg::SB_NO_DBG];
      user_id_o <= sec_reg[tbsl_pkg::SB_UID_HI:tbsl_pkg::SB_UID_LO];
    end
  end

  // ----------------------------------------------------------------
  // Wishbone registers and OTP programming
  // ----------------------------------------------------------------
  logic [15:0] prg_addr_reg;
  logic [31:0] prg_data_reg;
  logic deny_reg;
  logic wb_hit;
  logic wb_wr;
  logic go;
  logic to_sec;
  logic [tbsl_pkg::OTP_SEC_W-1:0] sector;
  logic refuse;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0];
  assign go = wb_wr && wb_adr_i == tbsl_pkg::REG_OTP_CTRL && wb_dat_i[tbsl_pkg::CTRL_GO];
  assign to_sec = wb_dat_i[tbsl_pkg::CTRL_TO_SEC];
  assign sector = prg_addr_reg[tbsl_pkg::OTP_ROW_W +: tbsl_pkg::OTP_SEC_W];
  assign refuse = !loaded_reg || sec_reg[tbsl_pkg::SB_MASTER] ||
                  (!to_sec && (prg_addr_reg >= 16'(tbsl_pkg::OTP_SECTORS * tbsl_pkg::OTP_ROWS) ||
                   sec_reg[tbsl_pkg::SB_LOCK0 + 32'(sector)]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          tbsl_pkg::REG_SECURITY: wb_dat_o <= sec_reg;
          tbsl_pkg::REG_STATUS: wb_dat_o <= {24'h000000, cpu_run_o, loaded_reg, deny_reg,
                                             crc_err_reg, 4'(state_reg)};
          tbsl_pkg::REG_OTP_ADDR: wb_dat_o <= {16'h0000, prg_addr_reg};
          tbsl_pkg::REG_OTP_DATA: wb_dat_o <= prg_data_reg;
          tbsl_pkg::REG_BOOT_LEN: wb_dat_o <= len_reg;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Port identities live in the package; software sees them as offsets here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prg_addr_reg <= '0;
      prg_data_reg <= '0;
      deny_reg <= 1'b0;
      otp_prog_o <= 1'b0;
      otp_prog_sec_o <= 1'b0;
      otp_prog_addr_o <= '0;
      otp_prog_data_o <= '0;
    end else begin
      otp_prog_o <= 1'b0;
      if (wb_wr && wb_adr_i == tbsl_pkg::REG_OTP_ADDR) begin
        prg_addr_reg <= wb_dat_i[15:0];
      end
      if (wb_hit && wb_we_i && wb_adr_i == tbsl_pkg::REG_OTP_DATA) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) prg_data_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
      if (go && !refuse) begin
        otp_prog_o <= 1'b1;
        otp_prog_sec_o <= to_sec;
        otp_prog_addr_o <= prg_addr_reg;
        otp_prog_data_o <= prg_data_reg;
      end
      // A new refusal beats a clear in the same write
      if (go && refuse) begin
        deny_reg <= 1'b1;
      end else if (wb_wr && wb_adr_i == tbsl_pkg::REG_OTP_CTRL &&
                   wb_dat_i[tbsl_pkg::CTRL_CLR]) begin
        deny_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_release;
    !chip_rst_n_i ##1 chip_rst_n_i;
  endsequence
  sequence s_quiet;
    !src_rd_o [*8];
  endsequence

  property p_pulldown;
    !chip_rst_n_i |=> gpio_pulldown_o;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down off in reset");

  property p_rstseq;
    (s_release ##0 chip_rst_n_i [*2]) |-> s_quiet;
  endproperty
  a_rstseq: assert property (p_rstseq) else $error("boot began too early");

  property p_secboot;
    (state_reg == tbsl_pkg::TBSL_SEC && take) |=>
      src_otp_o == $past(src_data_i[tbsl_pkg::SB_SEC_BOOT]) && src_addr_o == 16'h0000;
  endproperty
  a_secboot: assert property (p_secboot) else $error("wrong boot source");

  property p_skip;
    (chip_rst_n_i && state_reg == tbsl_pkg::TBSL_TRL && take &&
     src_data_i == tbsl_pkg::CRC_SKIP) |=> ##1 cpu_run_o;
  endproperty
  a_skip: assert property (p_skip) else $error("skip value not honoured");

  property p_badcrc;
    (chip_rst_n_i && state_reg == tbsl_pkg::TBSL_TRL && take &&
     src_data_i != tbsl_pkg::CRC_SKIP && src_data_i != crc_val) |=> ##1 !cpu_run_o && crc_err_reg;
  endproperty
  a_badcrc: assert property (p_badcrc) else $error("bad image started");

  property p_first_word;
    (state_reg == tbsl_pkg::TBSL_LEN && take && chip_rst_n_i) |=> ram_addr_o == '0;
  endproperty
  a_first_word: assert property (p_first_word) else $error("load not at base");

  property p_jtag;
    (loaded_reg && sec_reg[tbsl_pkg::SB_NO_JTAG]) |=> jtag_block_o;
  endproperty
  a_jtag: assert property (p_jtag) else $error("scan access not blocked");

  property p_master;
    (loaded_reg && sec_reg[tbsl_pkg::SB_MASTER]) |=> !otp_prog_o;
  endproperty
  a_master: assert property (p_master) else $error("programming under master lock");

  property p_lock;
    (go && !to_sec && sec_reg[tbsl_pkg::SB_LOCK0 + 32'(sector)]) |=> !otp_prog_o && deny_reg;
  endproperty
  a_lock: assert property (p_lock) else $error("locked sector programmed");

  property p_early;
    !loaded_reg |=> jtag_otp_block_o && link_block_o && debug_pin_off_o;
  endproperty
  a_early: assert property (p_early) else $error("feature open before load");

  property p_ack;
    wb_hit |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
endmodule
`default_nettype wire

// ==== verilog/tbsl_pkg.sv ====
// Package for the tile boot and security loader.
// Holds register offsets, security bit positions, image constants and timing counts.
package tbsl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RST_SEQ_US = 15;
  localparam int unsigned RST_SEQ_CYC = RST_SEQ_US * CLK_MHZ;
  localparam int unsigned RST_CNT_W = 12;

  // ----------------------------------------------------------------
  // Boot image
  // ----------------------------------------------------------------
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] BOOT_BASE = 16'h0000;
  localparam logic [15:0] OTP_SEC_ADDR = 16'h0800;

  // ----------------------------------------------------------------
  // One-time array shape
  // ----------------------------------------------------------------
  localparam int unsigned OTP_SECTORS = 4;
  localparam int unsigned OTP_ROWS = 512;
  localparam int unsigned OTP_ROW_W = 9;
  localparam int unsigned OTP_SEC_W = 2;

  // ----------------------------------------------------------------
  // Security register bits
  // ----------------------------------------------------------------
  localparam int unsigned SB_NO_JTAG = 0;
  localparam int unsigned SB_NO_LINK = 1;
  localparam int unsigned SB_SEC_BOOT = 5;
  localparam int unsigned SB_REDUND = 7;
  localparam int unsigned SB_LOCK0 = 8;
  localparam int unsigned SB_MASTER = 12;
  localparam int unsigned SB_NO_JOTP = 13;
  localparam int unsigned SB_NO_DBG = 14;
  localparam int unsigned SB_USER_LO = 15;
  localparam int unsigned SB_USER_HI = 21;
  localparam int unsigned SB_UID_LO = 22;
  localparam int unsigned SB_UID_HI = 31;

  // ----------------------------------------------------------------
  // Programming port identifiers
  // ----------------------------------------------------------------
  localparam logic [23:0] PID_OTP_ADDR = 24'h100200;
  localparam logic [23:0] PID_OTP_DATA = 24'h200100;
  localparam logic [23:0] PID_OTP_CTRL = 24'h100300;

  // ----------------------------------------------------------------
  // Wishbone register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SECURITY = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_OTP_ADDR = 8'h08;
  localparam logic [7:0] REG_OTP_DATA = 8'h0C;
  localparam logic [7:0] REG_OTP_CTRL = 8'h10;
  localparam logic [7:0] REG_BOOT_LEN = 8'h14;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_TO_SEC = 1;
  localparam int unsigned CTRL_CLR = 2;
  localparam int unsigned ST_CRC_ERR = 4;
  localparam int unsigned ST_DENY = 5;
  localparam int unsigned ST_LOADED = 6;
  localparam int unsigned ST_RUN = 7;

  typedef enum {
    TBSL_HOLD, TBSL_RSTSEQ, TBSL_SEC, TBSL_LEN, TBSL_PRG, TBSL_TRL, TBSL_RUN, TBSL_FAIL
  } tbsl_state_t;

endpackage
